// ==== rtl/lvrw_pkg.sv ====
// Purpose: shared constants and types of the low-voltage reset block
// Assumes: 200 MHz bus clock, 32-bit Avalon-MM register slave
// Notes: register offsets are byte addresses of aligned words
package lvrw_pkg;

    // ==========================================================
    // timing
    localparam int CLK_MHZ = 200;
    localparam int SRC_HOLD_NS = 100; // least hold for non-lvd resets
    localparam int SRC_HOLD_CYC = (SRC_HOLD_NS * CLK_MHZ + 999) / 1000;
    localparam logic [4:0] SRC_HOLD_LOAD = 5'(SRC_HOLD_CYC - 1);
    localparam logic [4:0] CNT_ZERO = 5'h00;

    // ==========================================================
    // register offsets
    localparam logic [7:0] OFS_CTRL = 8'h00;     // power_mgmt_control_one
    localparam logic [7:0] OFS_CAUSE = 8'h04;    // reset_cause_status
    localparam logic [7:0] OFS_IRQ_STAT = 8'h08;
    localparam logic [7:0] OFS_IRQ_MASK = 8'h0C;

    // control fields
    localparam int CB_DET_EN = 0;   // lowvolt_detect_enable
    localparam int CB_STOP_EN = 1;  // lowvolt_detect_stop_enable
    localparam int CB_RST_EN = 2;   // lowvolt_reset_enable
    localparam int CB_THR_SEL = 3;  // lowvolt_threshold_select
    localparam int CB_WIRQ_EN = 4;  // lowvolt_warning_irq_enable
    localparam int CB_WFLAG = 5;    // lowvolt_warning_flag, read only
    localparam int CB_WACK = 6;     // write one clears warning flag
    localparam logic [4:0] CTRL_RESET = 5'h05;

    // reset cause fields
    localparam int CS_POR = 7;
    localparam int CS_PIN = 6;
    localparam int CS_WDOG = 5;
    localparam int CS_ILOP = 4;
    localparam int CS_ILAD = 3;
    localparam int CS_LVD = 1;
    localparam logic [7:0] CAUSE_POR = 8'h82;

    // interrupt status / mask fields
    localparam int IB_WARN = 0;
    localparam int IB_TRIP = 1;
    localparam int IB_STOP_REF = 2;
    localparam int IRQ_W = 3;
    localparam logic [IRQ_W-1:0] IRQ_ZERO = 3'h0;

    // vectors, high byte at the lower address
    localparam logic [15:0] VEC_RESET_HI = 16'hFFFE;
    localparam logic [15:0] VEC_RESET_LO = 16'hFFFF;
    localparam logic [15:0] VEC_WARN_HI = 16'hFFF8;
    localparam logic [15:0] VEC_WARN_LO = 16'hFFF9;

    // ==========================================================
    // types
    // one bit per comparator, high while supply is below it
    typedef struct packed {
        logic warn_high;
        logic warn_low;
        logic det_high;
        logic det_low;
    } lvrw_cmp_type;

    localparam int SYNC_W = 5; // comparators plus reset pin
    localparam logic [SYNC_W-1:0] SYNC_RST = 5'h1F;

    typedef enum logic [3:0] {
        ST_POR_HOLD = 4'h1,
        ST_RUN = 4'h2,
        ST_LVD_HOLD = 4'h4,
        ST_SRC_HOLD = 4'h8
    } lvrw_state_type;

endpackage

// ==== rtl/lvrw_sync.sv ====
// Purpose: three-stage synchroniser for comparator and pin levels
// Assumes: inputs asynchronous to clk
// Notes: output moves only when stages two and three agree
module lvrw_sync (
    input wire logic clk,
    input wire logic rstn,
    input wire logic [lvrw_pkg::SYNC_W-1:0] async_in,
    output logic [lvrw_pkg::SYNC_W-1:0] sync_out
);
    import lvrw_pkg::*;

    // ==========================================================
    // per-bit chains
    genvar i;
    generate
        for (i = 0; i < SYNC_W; i++) begin : g_bit
            logic s1_reg;
            logic s2_reg;
            logic s3_reg;
            logic out_reg;
            wire agree = (s2_reg == s3_reg);
            // first stage feeds only the second
            always_ff @(posedge clk) begin
                if (!rstn) begin
                    s1_reg <= SYNC_RST[i];
                    s2_reg <= SYNC_RST[i];
                    s3_reg <= SYNC_RST[i];
                    out_reg <= SYNC_RST[i];
                end else begin
                    s1_reg <= async_in[i];
                    s2_reg <= s1_reg;
                    s3_reg <= s2_reg;
                    if (agree) begin
                        out_reg <= s3_reg;
                    end
                end
            end
            assign sync_out[i] = out_reg;
        end
    endgenerate

endmodule

// ==== rtl/lvrw_vector.sv ====
// Purpose: reset and warning vector bytes for the core fetch
// Assumes: core presents a 16-bit vector address each cycle
// Notes: byte answers one cycle after the address
module lvrw_vector (
    input wire logic clk,
    input wire logic rstn,
    input wire logic [15:0] vec_addr,
    input wire logic [15:0] reset_isr,
    input wire logic [15:0] warn_isr,
    output logic [7:0] vec_data
);
    import lvrw_pkg::*;

    // high byte at even address, low byte next
    function automatic logic [7:0] pick(input logic [15:0] isr,
                                        input logic lo);
        pick = lo ? isr[7:0] : isr[15:8];
    endfunction

    // ==========================================================
    // table decode
    wire hit_rst = (vec_addr == VEC_RESET_HI) | (vec_addr == VEC_RESET_LO);
    wire hit_warn = (vec_addr == VEC_WARN_HI) | (vec_addr == VEC_WARN_LO);
    wire [7:0] byte_next = hit_rst ? pick(reset_isr, vec_addr[0]) :
                           hit_warn ? pick(warn_isr, vec_addr[0]) : 8'h00;

    // registered answer
    always_ff @(posedge clk) begin
        if (!rstn) begin
            vec_data <= 8'h00;
        end else begin
            vec_data <= byte_next;
        end
    end

    property p_vec_order;
        @(posedge clk) disable iff (!rstn)
        vec_addr == VEC_RESET_HI |=> vec_data == $past(reset_isr[15:8]);
    endproperty
    a_vec_order: assert property (p_vec_order)
        else $error("reset vector high byte wrong");

endmodule

// ==== rtl/lvrw_top.sv ====
// Purpose: low-voltage reset, warning interrupt and reset routing
// Assumes: rstn is the power-on reset; core fetches vectors here
// Notes: registers over Avalon-MM with one wait state
// Function
// - Watchdog, low-voltage, pin, opcode, address resets share vector FFFE.
// - Low-voltage detection runs only while its enable bit is one.
// - Stop mode turns detection off unless the stop enable bit is set.
// - With both enables set, entry to deep stop is refused.
// - After power-on, reset holds until supply is above the low threshold.
// - Power-on sets both the power-on and low-voltage cause flags.
// - A low-voltage trip resets the system only while reset enable is one.
// - The threshold select bit picks which comparator is used.
// - A low-voltage reset holds until supply is back above the threshold.
// - A low-voltage reset also sets the low-voltage cause flag.
// - A warning with its interrupt enable set sets the flag and request.
// - Each vector has its high byte first, low byte at the next address.
// - The warning request reaches the core only while enabled.
module lvrw_top #(
    parameter logic [15:0] RESET_ISR = 16'h0000, // arbitrary default
    parameter logic [15:0] WARN_ISR = 16'h0000   // arbitrary default
) (
    input wire logic clk,
    input wire logic rstn,
    input wire logic [7:0] address,
    input wire logic read,
    input wire logic write,
    input wire logic [31:0] writedata,
    input wire logic [3:0] byteenable,
    output logic [31:0] readdata,
    output logic waitrequest,
    output logic irq,
    input wire lvrw_pkg::lvrw_cmp_type cmp_below,
    input wire logic reset_pin_n,
    input wire logic watchdog_timeout,
    input wire logic watchdog_enable,
    input wire logic illegal_opcode,
    input wire logic illegal_address,
    input wire logic stop_req,
    input wire logic stop_deep,
    output logic deep_stop_mode,
    output logic light_stop_mode,
    output logic lvd_power_en,
    output logic cpu_reset_n,
    output logic warn_irq_req,
    input wire logic [15:0] vec_addr,
    output logic [7:0] vec_data
);
    import lvrw_pkg::*;

    // ==========================================================
    // state
    lvrw_state_type st_reg, st_next;
    logic [4:0] ctrl_reg;
    logic warn_flag_reg;
    logic [7:0] cause_reg, cause_next;
    logic [IRQ_W-1:0] istat_reg, imask_reg;
    logic [4:0] cnt_reg, cnt_next;
    logic ack_reg, in_stop_reg, stop_q_reg, trip_q_reg;
    logic rst_n_reg, deep_reg, light_reg, pwr_reg;
    logic [31:0] rdata_reg;
    lvrw_cmp_type cmp_s;
    logic pin_n_s;

    // ==========================================================
    // input synchronisers and vector table
    lvrw_sync u_sync (
        .clk(clk),
        .rstn(rstn),
        .async_in({reset_pin_n, cmp_below}),
        .sync_out({pin_n_s, cmp_s})
    );

    lvrw_vector u_vec (
        .clk(clk),
        .rstn(rstn),
        .vec_addr(vec_addr),
        .reset_isr(RESET_ISR),
        .warn_isr(WARN_ISR),
        .vec_data(vec_data)
    );

    // ==========================================================
    // bus decode
    wire req = read | write;
    wire done = req & ack_reg;
    wire wr_ctrl = done & write & byteenable[0] & (address == OFS_CTRL);
    wire wr_mask = done & write & byteenable[0] & (address == OFS_IRQ_MASK);
    wire rd_istat = done & read & (address == OFS_IRQ_STAT);
    wire wack = wr_ctrl & writedata[CB_WACK];
    assign waitrequest = req & ~ack_reg;

    // control fields
    wire det_en = ctrl_reg[CB_DET_EN];
    wire stop_en = ctrl_reg[CB_STOP_EN];
    wire rst_en = ctrl_reg[CB_RST_EN];
    wire thr_sel = ctrl_reg[CB_THR_SEL];
    wire wirq_en = ctrl_reg[CB_WIRQ_EN];

    // ==========================================================
    // detection path
    wire det_active = det_en & (~in_stop_reg | stop_en);
    wire det_below = thr_sel ? cmp_s.det_high : cmp_s.det_low;
    wire warn_below = thr_sel ? cmp_s.warn_high : cmp_s.warn_low;
    wire trip = det_active & det_below;
    wire lvd_rst = trip & rst_en;
    wire deep_block = det_en & stop_en;

    // reset sources, all onto the one reset vector
    wire wdog_src = watchdog_timeout & watchdog_enable;
    wire pin_src = ~pin_n_s;
    wire other_src = wdog_src | pin_src | illegal_opcode | illegal_address;

    // warning flag set and hold
    wire wset = det_active & warn_below & wirq_en;
    wire warn_flag_next = wset | (warn_flag_reg & ~wack);

    // interrupt events, set beats read clear
    wire [IRQ_W-1:0] ievt = {stop_req & ~stop_q_reg & stop_deep & deep_block,
                             trip & ~trip_q_reg,
                             wset & ~warn_flag_reg};
    // a read clears only the bits it returned, so later events survive
    wire [IRQ_W-1:0] rd_clr = rd_istat ? rdata_reg[IRQ_W-1:0] : IRQ_ZERO;
    wire [IRQ_W-1:0] istat_next = ievt | (istat_reg & ~rd_clr);

    // read mux
    wire [31:0] rd_mux =
        (address == OFS_CTRL) ? {26'h0, warn_flag_reg, ctrl_reg} :
        (address == OFS_CAUSE) ? {24'h0, cause_reg} :
        (address == OFS_IRQ_STAT) ? {29'h0, istat_reg} :
        (address == OFS_IRQ_MASK) ? {29'h0, imask_reg} : 32'h0;

    // ==========================================================
    // reset sequencer
    always_comb begin
        st_next = st_reg;
        cnt_next = cnt_reg;
        cause_next = cause_reg;
        unique case (st_reg)
            ST_POR_HOLD: begin
                if (!cmp_s.det_low) begin
                    st_next = ST_RUN;
                end
            end
            ST_RUN: begin
                if (lvd_rst) begin
                    st_next = ST_LVD_HOLD;
                    cause_next = cause_reg & (8'h01 << CS_POR);
                    cause_next[CS_LVD] = 1'b1;
                end else if (other_src) begin
                    st_next = ST_SRC_HOLD;
                    cnt_next = SRC_HOLD_LOAD;
                    cause_next = 8'h00;
                    cause_next[CS_PIN] = pin_src;
                    cause_next[CS_WDOG] = wdog_src;
                    cause_next[CS_ILOP] = illegal_opcode;
                    cause_next[CS_ILAD] = illegal_address;
                end
            end
            ST_LVD_HOLD: begin
                if (!det_below) begin
                    st_next = ST_RUN;
                end
            end
            ST_SRC_HOLD: begin
                if (cnt_reg != CNT_ZERO) begin
                    cnt_next = cnt_reg - 5'h01;
                end else if (!pin_src) begin
                    st_next = ST_RUN;
                end
            end
        endcase
    end

    // sequencer and reset output
    always_ff @(posedge clk) begin
        if (!rstn) begin
            st_reg <= ST_POR_HOLD;
            cnt_reg <= CNT_ZERO;
            cause_reg <= CAUSE_POR;
            rst_n_reg <= 1'b0;
        end else begin
            st_reg <= st_next;
            cnt_reg <= cnt_next;
            cause_reg <= cause_next;
            rst_n_reg <= (st_next == ST_RUN);
        end
    end

    // stop mode and detector power
    always_ff @(posedge clk) begin
        if (!rstn) begin
            in_stop_reg <= 1'b0;
            stop_q_reg <= 1'b0;
            deep_reg <= 1'b0;
            light_reg <= 1'b0;
            pwr_reg <= 1'b0;
        end else begin
            in_stop_reg <= stop_req & (st_reg == ST_RUN);
            stop_q_reg <= stop_req;
            deep_reg <= in_stop_reg & stop_deep & ~deep_block;
            light_reg <= in_stop_reg & (~stop_deep | deep_block);
            pwr_reg <= det_active;
        end
    end

    // registers and bus handshake
    always_ff @(posedge clk) begin
        if (!rstn) begin
            ctrl_reg <= CTRL_RESET;
            imask_reg <= IRQ_ZERO;
            istat_reg <= IRQ_ZERO;
            warn_flag_reg <= 1'b0;
            trip_q_reg <= 1'b0;
            ack_reg <= 1'b0;
            rdata_reg <= 32'h0;
        end else begin
            if (wr_ctrl) begin
                ctrl_reg <= writedata[4:0];
            end
            if (wr_mask) begin
                imask_reg <= writedata[IRQ_W-1:0];
            end
            istat_reg <= istat_next;
            warn_flag_reg <= warn_flag_next;
            trip_q_reg <= trip;
            ack_reg <= req & ~ack_reg;
            if (req & ~ack_reg) begin
                rdata_reg <= rd_mux;
            end
        end
    end

    // outputs
    assign readdata = rdata_reg;
    assign irq = |(istat_reg & imask_reg);
    assign cpu_reset_n = rst_n_reg;
    assign deep_stop_mode = deep_reg;
    assign light_stop_mode = light_reg;
    assign lvd_power_en = pwr_reg;
    assign warn_irq_req = warn_flag_reg & wirq_en;

    // ==========================================================
    // checks
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rstn);

    property p_src_reset;
        st_reg == ST_RUN && other_src |-> ##[1:2] !cpu_reset_n;
    endproperty
    a_src_reset: assert property (p_src_reset)
        else $error("reset source did not reset core");

    property p_det_off;
        !det_en |=> !lvd_power_en;
    endproperty
    a_det_off: assert property (p_det_off)
        else $error("detector powered while disabled");

    property p_stop_off;
        in_stop_reg && !stop_en |=> !lvd_power_en;
    endproperty
    a_stop_off: assert property (p_stop_off)
        else $error("detector powered in stop");

    property p_deep_ref;
        $rose(deep_stop_mode) |-> !$past(deep_block);
    endproperty
    a_deep_ref: assert property (p_deep_ref)
        else $error("deep stop entered while refused");

    property p_por_hold;
        st_reg == ST_POR_HOLD && cmp_s.det_low |=> !cpu_reset_n;
    endproperty
    a_por_hold: assert property (p_por_hold)
        else $error("released before supply good");

    property p_por_cause;
        $past(!rstn) |-> cause_reg[CS_POR] && cause_reg[CS_LVD];
    endproperty
    a_por_cause: assert property (p_por_cause)
        else $error("power-on cause flags missing");

    property p_no_rst;
        st_reg == ST_RUN && !rst_en |=> st_reg != ST_LVD_HOLD;
    endproperty
    a_no_rst: assert property (p_no_rst)
        else $error("lvd reset while disabled");

    property p_thr;
        st_reg == ST_LVD_HOLD && thr_sel && cmp_s.det_high
            |=> st_reg == ST_LVD_HOLD;
    endproperty
    a_thr: assert property (p_thr)
        else $error("wrong threshold used");

    property p_lvd_hold;
        st_reg == ST_LVD_HOLD && det_below
            |=> !cpu_reset_n && st_reg == ST_LVD_HOLD;
    endproperty
    a_lvd_hold: assert property (p_lvd_hold)
        else $error("lvd hold released early");

    property p_lvd_cause;
        st_reg == ST_RUN && lvd_rst |=> cause_reg[CS_LVD] && !cpu_reset_n;
    endproperty
    a_lvd_cause: assert property (p_lvd_cause)
        else $error("lvd cause flag not set");

    property p_warn_set;
        wset |=> warn_flag_reg && warn_irq_req == wirq_en;
    endproperty
    a_warn_set: assert property (p_warn_set)
        else $error("warning flag not set");

    property p_warn_gate;
        warn_irq_req |-> warn_flag_reg && wirq_en;
    endproperty
    a_warn_gate: assert property (p_warn_gate)
        else $error("warning request while masked");

    property p_warn_keep;
        warn_flag_reg && !wack |=> warn_flag_reg;
    endproperty
    a_warn_keep: assert property (p_warn_keep)
        else $error("warning flag lost");

endmodule

// ==== dv/lvrw_core_model.sv ====
// Purpose: core-side model fetching vectors and requesting stop
// Assumes: vec_data answers one cycle after vec_addr
// Notes: idle address is a neutral non-vector value
module lvrw_core_model (
    input wire logic clk,
    input wire logic [7:0] vec_data,
    output logic [15:0] vec_addr,
    output logic stop_req,
    output logic stop_deep
);
    timeunit 1ns;
    timeprecision 1ps;

    // ======================================
    // idle levels
    initial begin
        vec_addr = 16'h0000;
        stop_req = 1'b0;
        stop_deep = 1'b0;
    end

    // two-byte vector fetch, high byte at the lower address
    task automatic fetch(input logic [15:0] a, output logic [15:0] isr);
        @(posedge clk);
        vec_addr <= a;
        @(posedge clk);
        vec_addr <= a + 16'h0001;
        @(negedge clk);
        isr[15:8] = vec_data;
        @(posedge clk);
        vec_addr <= 16'h0000;
        @(negedge clk);
        isr[7:0] = vec_data;
    endtask

    // stop request levels
    task automatic stop(input logic r, input logic d);
        @(posedge clk);
        stop_req <= r;
        stop_deep <= d;
    endtask
endmodule

// ==== dv/tb_top.sv ====
// Purpose: self-checking bench of the low-voltage reset block
// Assumes: one wait state on the register bus
// Notes: threshold select 0 picks the low comparator
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    import lvrw_pkg::*;

    // ======================================
    // signals
    localparam logic [15:0] RISR = 16'h12C4;
    localparam logic [15:0] WISR = 16'h3E71;
    logic clk = 1'b0, rstn = 1'b0, read = 1'b0, write = 1'b0;
    logic [7:0] address = 8'h00;
    logic [31:0] writedata = 32'h0, readdata;
    logic [3:0] byteenable = 4'hF;
    logic waitrequest, irq, deep_stop_mode, light_stop_mode;
    logic lvd_power_en, cpu_reset_n, warn_irq_req, stop_req, stop_deep;
    lvrw_cmp_type cmp_below = 4'hF;
    logic reset_pin_n = 1'b1, watchdog_timeout = 1'b0;
    logic watchdog_enable = 1'b1, illegal_opcode = 1'b0;
    logic illegal_address = 1'b0;
    logic [15:0] vec_addr;
    logic [7:0] vec_data;
    int err_count = 0, checked = 0, cyc = 0;

    lvrw_top #(.RESET_ISR(RISR), .WARN_ISR(WISR)) i_lvrw_top (
        .clk(clk), .rstn(rstn), .address(address), .read(read),
        .write(write), .writedata(writedata), .byteenable(byteenable),
        .readdata(readdata), .waitrequest(waitrequest), .irq(irq),
        .cmp_below(cmp_below), .reset_pin_n(reset_pin_n),
        .watchdog_timeout(watchdog_timeout),
        .watchdog_enable(watchdog_enable), .illegal_opcode(illegal_opcode),
        .illegal_address(illegal_address), .stop_req(stop_req),
        .stop_deep(stop_deep), .deep_stop_mode(deep_stop_mode),
        .light_stop_mode(light_stop_mode), .lvd_power_en(lvd_power_en),
        .cpu_reset_n(cpu_reset_n), .warn_irq_req(warn_irq_req),
        .vec_addr(vec_addr), .vec_data(vec_data));

    lvrw_core_model i_lvrw_core_model (
        .clk(clk), .vec_data(vec_data), .vec_addr(vec_addr),
        .stop_req(stop_req), .stop_deep(stop_deep));

    // ======================================
    // clock and hang guard
    always #2.5 clk = ~clk;
    always @(posedge clk) begin
        cyc++;
        if (cyc == 20000) begin
            err_count++;
            final_report();
        end
    end

    task automatic final_report();
        if (err_count == 0 && checked > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, exp, input string m);
        checked++;
        if (got !== exp) begin
            err_count++;
            $display("BAD %0t %s got %h exp %h", $time, m, got, exp);
        end
    endtask

    // avalon access, held until waitrequest is seen low
    task automatic bus(input logic wr, input logic [7:0] a,
                       input logic [31:0] d, output logic [31:0] q);
        int n;
        @(posedge clk);
        address <= a;
        read <= ~wr;
        write <= wr;
        writedata <= d;
        n = 0;
        do begin
            @(negedge clk);
            n++;
        end while (waitrequest !== 1'b0);
        chk(n, 32'h2, "wait state");
        @(posedge clk);
        q = readdata;
        read <= 1'b0;
        write <= 1'b0;
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] q;
        bus(1'b1, a, d, q);
    endtask

    task automatic setc(input logic [3:0] v);
        @(posedge clk);
        cmp_below <= v;
        repeat (6) @(posedge clk); // synchroniser settles
    endtask

    task automatic wait_rst(input logic v, input int lim);
        int n;
        n = 0;
        while (cpu_reset_n !== v && n < lim) begin
            @(negedge clk);
            n++;
        end
    endtask

    task automatic idle(input int n, input logic v, input string m);
        repeat (n) @(negedge clk);
        chk(cpu_reset_n, v, m);
    endtask

    // ======================================
    // scenarios
    task automatic t_por();
        logic [31:0] q;
        logic [15:0] isr;
        repeat (3) @(posedge clk);
        rstn <= 1'b1;
        idle(10, 1'b0, "por hold");
        setc(4'h0);
        wait_rst(1'b1, 20);
        chk(cpu_reset_n, 1'b1, "por release");
        bus(1'b0, OFS_CAUSE, 32'h0, q);
        chk(q, 32'h82, "por cause");
        bus(1'b0, OFS_CTRL, 32'h0, q);
        chk(q, 32'h05, "ctrl reset");
        bus(1'b0, 8'h10, 32'h0, q);
        chk(q, 32'h0, "unmapped");
        i_lvrw_core_model.fetch(VEC_RESET_HI, isr);
        chk(isr, RISR, "reset vector");
    endtask

    task automatic t_src();
        int b[4] = '{CS_ILOP, CS_ILAD, CS_WDOG, CS_PIN};
        logic [31:0] q;
        logic [15:0] isr;
        @(posedge clk);
        watchdog_enable <= 1'b0;
        watchdog_timeout <= 1'b1;
        idle(10, 1'b1, "gated watchdog");
        @(posedge clk) watchdog_timeout <= 1'b0;
        watchdog_enable <= 1'b1;
        for (int k = 0; k < 4; k++) begin
            @(posedge clk);
            illegal_opcode <= (k == 0);
            illegal_address <= (k == 1);
            watchdog_timeout <= (k == 2);
            reset_pin_n <= (k != 3);
            wait_rst(1'b0, 10);
            chk(cpu_reset_n, 1'b0, "source reset");
            @(posedge clk);
            {illegal_opcode, illegal_address, watchdog_timeout} <= 3'h0;
            reset_pin_n <= 1'b1;
            idle(10, 1'b0, "source hold");
            wait_rst(1'b1, 60);
            bus(1'b0, OFS_CAUSE, 32'h0, q);
            chk(q, 32'h1 << b[k], "source cause");
            i_lvrw_core_model.fetch(VEC_RESET_HI, isr);
            chk(isr, RISR, "source vector");
        end
    endtask

    task automatic t_lvd();
        logic [31:0] q;
        wr(OFS_CTRL, 32'h05);
        setc(4'h1);
        wait_rst(1'b0, 10);
        chk(cpu_reset_n, 1'b0, "lvd reset");
        idle(40, 1'b0, "lvd hold");
        setc(4'h0);
        wait_rst(1'b1, 10);
        chk(cpu_reset_n, 1'b1, "lvd release");
        bus(1'b0, OFS_CAUSE, 32'h0, q);
        chk(q, 32'h02, "lvd cause");
        wr(OFS_CTRL, 32'h04);
        setc(4'h1);
        idle(10, 1'b1, "detect off");
        chk(lvd_power_en, 1'b0, "detect power");
        setc(4'h0);
        wr(OFS_CTRL, 32'h01);
        setc(4'h1);
        idle(10, 1'b1, "reset disabled");
        setc(4'h0);
    endtask

    task automatic t_thr();
        wr(OFS_CTRL, 32'h05);
        setc(4'h2);
        idle(10, 1'b1, "low thr used");
        setc(4'h0);
        wr(OFS_CTRL, 32'h0D);
        setc(4'h2);
        wait_rst(1'b0, 10);
        chk(cpu_reset_n, 1'b0, "high thr used");
        setc(4'h0);
        wait_rst(1'b1, 10);
        chk(cpu_reset_n, 1'b1, "high thr release");
    endtask

    task automatic t_warn();
        logic [31:0] q;
        logic [15:0] isr;
        wr(OFS_CTRL, 32'h11);
        bus(1'b0, OFS_IRQ_STAT, 32'h0, q);
        wr(OFS_IRQ_MASK, 32'h0);
        setc(4'hC);
        repeat (6) @(negedge clk);
        chk(warn_irq_req, 1'b1, "warn request");
        chk(irq, 1'b0, "masked irq");
        bus(1'b0, OFS_CTRL, 32'h0, q);
        chk(q[CB_WFLAG], 1'b1, "warn flag");
        wr(OFS_IRQ_MASK, 32'h1);
        @(negedge clk) chk(irq, 1'b1, "unmasked irq");
        setc(4'h0);
        repeat (10) @(negedge clk);
        chk(warn_irq_req, 1'b1, "flag sticky");
        wr(OFS_CTRL, 32'h51);
        @(negedge clk) chk(warn_irq_req, 1'b0, "flag acked");
        bus(1'b0, OFS_IRQ_STAT, 32'h0, q);
        chk(q[IB_WARN], 1'b1, "warn status");
        @(negedge clk) chk(irq, 1'b0, "irq cleared");
        i_lvrw_core_model.fetch(VEC_WARN_HI, isr);
        chk(isr, WISR, "warn vector");
        setc(4'hC);
        wr(OFS_CTRL, 32'h01);
        @(negedge clk) chk(warn_irq_req, 1'b0, "warn disabled");
        bus(1'b0, OFS_CTRL, 32'h0, q);
        chk(q[CB_WFLAG], 1'b1, "flag kept");
        setc(4'h0);
        wr(OFS_IRQ_MASK, 32'h0);
    endtask

    task automatic t_stop();
        logic [31:0] q;
        wr(OFS_CTRL, 32'h03);
        bus(1'b0, OFS_IRQ_STAT, 32'h0, q);
        i_lvrw_core_model.stop(1'b1, 1'b1);
        repeat (3) @(negedge clk);
        chk(deep_stop_mode, 1'b0, "deep refused");
        chk(light_stop_mode, 1'b1, "light instead");
        chk(lvd_power_en, 1'b1, "stop keeps detect");
        bus(1'b0, OFS_IRQ_STAT, 32'h0, q);
        chk(q[IB_STOP_REF], 1'b1, "refuse status");
        i_lvrw_core_model.stop(1'b0, 1'b0);
        wr(OFS_CTRL, 32'h01);
        i_lvrw_core_model.stop(1'b1, 1'b1);
        repeat (3) @(negedge clk);
        chk(deep_stop_mode, 1'b1, "deep entered");
        chk(lvd_power_en, 1'b0, "stop detect off");
        i_lvrw_core_model.stop(1'b0, 1'b0);
        repeat (3) @(negedge clk);
        chk(lvd_power_en, 1'b1, "run detect on");
    endtask

    // ======================================
    // main sequence
    initial begin
        t_por();
        t_src();
        t_lvd();
        t_thr();
        t_warn();
        t_stop();
        final_report();
    end
endmodule
